// file: common/adc_conv_pkg.sv
// Functional notes
// RQ1: Go write starts or restarts conversion.
// RQ2: Go bit reads 1 while busy; zero write ignored.
// RQ3: Single shot result after 5129 cycles.
// RQ4: Continuous: first 5129, then every 256.
// RQ5: Temperature sensor doubles both intervals.
// RQ6: Reference select decodes external, 1.0 V, 2.0 V.
// RQ7: Reference output bit drives reference buffer.
// RQ8: Software keeps reference output off with external.
// RQ9: Single-ended codes pick inputs, ground, sensor.
// RQ10: Reserved input codes open all switches.
// RQ11: Differential codes pick pairs or short inputs.
// RQ12: Input decode depends on buffer mode.
// RQ13: Buffer mode decodes four legal settings.
// RQ14: Alarm flags set by hardware, write-one clears.
// RQ15: Disabled alarm still sets its flag.
// RQ16: Result is 13-bit, high byte read-only.
// RQ17: High byte read latches low bits.
// RQ18: Continuous mode holds latest completed result.
// RQ19: Software uses buffered mode for amplifier output.
// RQ20: Amplifier power bit active low, off by default.
// RQ21: Reference select resets to internal 2.0 V.
// RQ22: Low bits: five result bits, overflow bit 0.
// RQ23: Alarms compare upper byte, single-ended only.
// RQ24: Interrupt when enabled alarm flag set.
// RQ25: Restart reloads counter, result waits for completion.
package adc_conv_pkg;

	// ****************************************
	// Register map.
	// ****************************************
	localparam logic [11:0] conversion_control_addr      = 12'hf70;
	localparam logic [11:0] converter_config_status_addr = 12'hf71;
	localparam logic [11:0] result_high_byte_addr        = 12'hf72;
	localparam logic [11:0] result_low_bits_addr         = 12'hf73;
	localparam logic [11:0] high_threshold_addr          = 12'hf74;
	localparam logic [11:0] low_threshold_addr           = 12'hf76;
	localparam logic [11:0] power_control_addr           = 12'hf78;

	// ****************************************
	// Field positions.
	// ****************************************
	localparam int convert_go_bit        = 7;
	localparam int vref_sel_lo_bit       = 6;
	localparam int vref_drive_out_bit    = 5;
	localparam int repeat_conversion_bit = 4;
	localparam int vref_sel_hi_bit       = 7;
	localparam int high_alarm_flag_bit   = 6;
	localparam int low_alarm_flag_bit    = 5;
	localparam int high_alarm_irq_en_bit = 4;
	localparam int low_alarm_irq_en_bit  = 3;
	localparam int low_power_amp_bit     = 0;

	// ****************************************
	// Reset values.
	// ****************************************
	localparam logic [7:0] conversion_control_rst      = 8'h00;
	localparam logic [7:0] converter_config_status_rst = 8'h80;
	localparam logic [7:0] high_threshold_rst          = 8'hff;
	localparam logic [7:0] low_threshold_rst           = 8'h00;
	localparam logic       low_power_amp_rst           = 1'h1;

	// ****************************************
	// Timing.
	// ****************************************
	localparam int first_result_cycles  = 5129;
	localparam int update_cycles        = 256;
	localparam logic [13:0] first_count = 14'(first_result_cycles - 1);
	localparam logic [13:0] update_count = 14'(update_cycles - 1);

	// ****************************************
	// Codes.
	// ****************************************
	localparam logic [3:0] input_ground_code = 4'hc;
	localparam logic [3:0] input_temp_code   = 4'he;
	localparam logic [3:0] diff_last_pair    = 4'ha;
	localparam logic [3:0] diff_short_code   = 4'hf;

	typedef enum logic [1:0]
	{
		vref_external = 2'b00,
		vref_1v0      = 2'b01,
		vref_2v0      = 2'b10,
		vref_reserved = 2'b11
	} vref_t;

	typedef enum logic [2:0]
	{
		buf_se_unbuf   = 3'b000,
		buf_se_unity   = 3'b001,
		buf_diff_unbuf = 3'b100,
		buf_diff_unity = 3'b101
	} buffer_mode_t;

	typedef enum logic [1:0]
	{
		st_idle  = 2'b00,
		st_first = 2'b01,
		st_next  = 2'b10
	} conv_state_t;

endpackage : adc_conv_pkg

// file: core/adc_input_decode.sv
`timescale 1ns/10ps
// Decodes input select and buffer mode into analog switch controls.
module adc_input_decode
(
	input  wire logic [3:0]  i_input_select,
	input  wire logic [2:0]  i_buffer_config,
	output logic      [7:0]  o_pos_switch,
	output logic      [7:0]  o_neg_switch,
	output logic             o_ground_nodes,
	output logic             o_temp_sel,
	output logic             o_diff_short,
	output logic             o_diff_mode,
	output logic             o_buffered
);

	// ****************************************
	// Pair table for differential codes.
	// ****************************************
	logic [2:0] pos_idx;
	logic [2:0] neg_idx;
	logic       mode_ok;

	// Mode decode; reserved modes open every switch.
	always_comb
	begin
		mode_ok     = 1'b1;
		o_diff_mode = 1'b0;
		o_buffered  = 1'b0;
		unique case (i_buffer_config) // [RQ13]
			adc_conv_pkg::buf_se_unbuf:   o_diff_mode = 1'b0;
			adc_conv_pkg::buf_se_unity:   o_buffered = 1'b1;
			adc_conv_pkg::buf_diff_unbuf: o_diff_mode = 1'b1;
			adc_conv_pkg::buf_diff_unity:
			begin
				o_diff_mode = 1'b1;
				o_buffered  = 1'b1;
			end
			default: mode_ok = 1'b0;
		endcase
	end

	// Differential pair lookup.
	always_comb
	begin
		pos_idx = 3'h0;
		neg_idx = 3'h0;
		unique case (i_input_select) // [RQ11]
			4'h0: begin pos_idx = 3'h0; neg_idx = 3'h1; end
			4'h1: begin pos_idx = 3'h2; neg_idx = 3'h3; end
			4'h2: begin pos_idx = 3'h4; neg_idx = 3'h5; end
			4'h3: begin pos_idx = 3'h1; neg_idx = 3'h0; end
			4'h4: begin pos_idx = 3'h3; neg_idx = 3'h2; end
			4'h5: begin pos_idx = 3'h5; neg_idx = 3'h4; end
			4'h6: begin pos_idx = 3'h6; neg_idx = 3'h5; end
			4'h7: begin pos_idx = 3'h0; neg_idx = 3'h2; end
			4'h8: begin pos_idx = 3'h0; neg_idx = 3'h3; end
			4'h9: begin pos_idx = 3'h0; neg_idx = 3'h4; end
			4'ha: begin pos_idx = 3'h0; neg_idx = 3'h5; end
			default: begin pos_idx = 3'h0; neg_idx = 3'h0; end
		endcase
	end

	// Switch outputs; reserved codes leave all open.
	always_comb
	begin
		o_pos_switch   = 8'h00;
		o_neg_switch   = 8'h00;
		o_ground_nodes = 1'b0;
		o_temp_sel     = 1'b0;
		o_diff_short   = 1'b0;
		if (mode_ok && !o_diff_mode) // [RQ12]
		begin
			if (!i_input_select[3]) // [RQ9]
				o_pos_switch = 8'h01 << i_input_select[2:0];
			else if (i_input_select == adc_conv_pkg::input_ground_code)
				o_ground_nodes = 1'b1;
			else if (i_input_select == adc_conv_pkg::input_temp_code)
				o_temp_sel = 1'b1;
		end
		else if (mode_ok) // [RQ12]
		begin
			if (i_input_select <= adc_conv_pkg::diff_last_pair)
			begin
				o_pos_switch = 8'h01 << pos_idx;
				o_neg_switch = 8'h01 << neg_idx;
			end
			else if (i_input_select == adc_conv_pkg::diff_short_code) // [RQ11]
				o_diff_short = 1'b1;
		end
		// Any other code falls through with switches open. [RQ10]
	end

endmodule : adc_input_decode

// file: core/adc_conversion_control.sv
`timescale 1ns/10ps
// Control and result logic of the converter.
module adc_conversion_control
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic [12:0] i_core_sample,
	input  wire logic        i_core_overflow,
	output logic             o_core_start,
	output logic             o_sample_strobe,
	output logic      [1:0]  o_vref_sel,
	output logic             o_internal_ref_on,
	output logic             o_vref_drive_out,
	output logic      [7:0]  o_pos_switch,
	output logic      [7:0]  o_neg_switch,
	output logic             o_ground_nodes,
	output logic             o_temp_sel,
	output logic             o_diff_short,
	output logic             o_input_buffered,
	output logic             o_amp_power_on,
	output logic             o_irq
);

	// ****************************************
	// Register storage.
	// ****************************************
	logic [7:0]  control_reg;
	logic [7:0]  config_reg;
	logic [7:0]  high_threshold_reg;
	logic [7:0]  low_threshold_reg;
	logic        amp_power_b_reg;
	logic [12:0] result_reg;
	logic        overflow_reg;
	logic [4:0]  low_latch_reg;
	logic        low_ovf_latch_reg;
	logic [7:0]  rdata_reg;
	logic [13:0] count_reg;
	logic [13:0] count_next;
	logic        extra_pass_reg;
	logic        busy_reg;
	adc_conv_pkg::conv_state_t state_reg;
	adc_conv_pkg::conv_state_t state_next;

	logic        wr_control;
	logic        wr_config;
	logic        go_write;
	logic        go_temp;
	logic        count_done;
	logic        complete;
	logic [7:0]  pos_sw;
	logic [7:0]  neg_sw;
	logic        ground_sw;
	logic        temp_sw;
	logic        short_sw;
	logic        diff_mode;
	logic        buffered;
	logic        high_hit;
	logic        low_hit;

	assign wr_control = i_wr && (i_addr == adc_conv_pkg::conversion_control_addr);
	assign wr_config  = i_wr && (i_addr == adc_conv_pkg::converter_config_status_addr);
	assign go_write   = wr_control && i_wdata[adc_conv_pkg::convert_go_bit]; // [RQ1]
	// A go write takes its input code only at this edge, so the sensor test looks at the new code.
	assign go_temp    = (i_wdata[3:0] == adc_conv_pkg::input_temp_code) && (config_reg[2:1] == 2'b00);

	// ****************************************
	// Input switch decode.
	// ****************************************
	adc_input_decode u_decode
	(
		.i_input_select  (control_reg[3:0]),
		.i_buffer_config (config_reg[2:0]),
		.o_pos_switch    (pos_sw),
		.o_neg_switch    (neg_sw),
		.o_ground_nodes  (ground_sw),
		.o_temp_sel      (temp_sw),
		.o_diff_short    (short_sw),
		.o_diff_mode     (diff_mode),
		.o_buffered      (buffered)
	);

	// ****************************************
	// Conversion sequencer.
	// ****************************************
	// The sensor pass needs two runs of each interval, tracked by extra_pass_reg.
	assign count_done = (count_reg == 14'h0000);
	assign complete   = (state_reg != adc_conv_pkg::st_idle) && !go_write
		&& count_done && (extra_pass_reg == 1'b0); // [RQ25]

	// Next state and counter load.
	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg - 14'h0001;
		if (go_write) // [RQ1] [RQ25]
		begin
			state_next = adc_conv_pkg::st_first;
			count_next = adc_conv_pkg::first_count; // [RQ3]
		end
		else
		begin
			unique case (state_reg)
				adc_conv_pkg::st_idle: count_next = count_reg;
				adc_conv_pkg::st_first,
				adc_conv_pkg::st_next:
				begin
					if (count_done && extra_pass_reg)
						count_next = (state_reg == adc_conv_pkg::st_first) ?
							adc_conv_pkg::first_count : adc_conv_pkg::update_count;
					else if (count_done && control_reg[adc_conv_pkg::repeat_conversion_bit])
					begin
						state_next = adc_conv_pkg::st_next; // [RQ4]
						count_next = adc_conv_pkg::update_count;
					end
					else if (count_done)
						state_next = adc_conv_pkg::st_idle;
				end
			endcase
		end
	end

	// State and counter update.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg      <= adc_conv_pkg::st_idle;
			count_reg      <= 14'h0000;
			extra_pass_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
			if (go_write)
				extra_pass_reg <= go_temp; // [RQ5]
			else if (count_done && !extra_pass_reg && state_reg != adc_conv_pkg::st_idle)
				extra_pass_reg <= temp_sw; // [RQ5]
			else if (count_done)
				extra_pass_reg <= 1'b0;
		end
	end

	// Busy flag: set by go write, cleared on completion when not repeating.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			busy_reg <= 1'b0;
		else if (go_write)
			busy_reg <= 1'b1; // [RQ1]
		else if (complete && state_next == adc_conv_pkg::st_idle)
			busy_reg <= 1'b0; // [RQ2]
	end

	// Result capture only on completion.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			result_reg      <= 13'h0000;
			overflow_reg    <= 1'b0;
			o_sample_strobe <= 1'b0;
			o_core_start    <= 1'b0;
		end
		else
		begin
			o_sample_strobe <= complete;
			o_core_start    <= go_write;
			if (complete)
			begin
				result_reg   <= i_core_sample; // [RQ16] [RQ18] [RQ25]
				overflow_reg <= i_core_overflow; // [RQ22]
			end
		end
	end

	// ****************************************
	// Alarm comparison.
	// ****************************************
	assign high_hit = complete && !diff_mode && // [RQ23]
		($signed(i_core_sample[12:5]) > $signed(high_threshold_reg));
	assign low_hit  = complete && !diff_mode && // [RQ23]
		($signed(i_core_sample[12:5]) < $signed(low_threshold_reg));

	// ****************************************
	// Control and configuration registers.
	// ****************************************
	// Control register; go bit mirrors busy.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			control_reg <= adc_conv_pkg::conversion_control_rst;
		else if (wr_control)
			control_reg <= {1'b0, i_wdata[6:0]};
	end

	// Config register; alarm flags are set-wins over write-one clear.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			config_reg <= adc_conv_pkg::converter_config_status_rst; // [RQ21]
		else
		begin
			if (wr_config)
			begin
				config_reg[7]   <= i_wdata[adc_conv_pkg::vref_sel_hi_bit];
				config_reg[4:0] <= i_wdata[4:0];
			end
			if (high_hit)
				config_reg[6] <= 1'b1; // [RQ14] [RQ15]
			else if (wr_config && i_wdata[adc_conv_pkg::high_alarm_flag_bit])
				config_reg[6] <= 1'b0; // [RQ14]
			if (low_hit)
				config_reg[5] <= 1'b1; // [RQ14] [RQ15]
			else if (wr_config && i_wdata[adc_conv_pkg::low_alarm_flag_bit])
				config_reg[5] <= 1'b0; // [RQ14]
		end
	end

	// Threshold and amplifier power registers.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			high_threshold_reg <= adc_conv_pkg::high_threshold_rst;
			low_threshold_reg  <= adc_conv_pkg::low_threshold_rst;
			amp_power_b_reg    <= adc_conv_pkg::low_power_amp_rst; // [RQ20]
		end
		else if (i_wr)
		begin
			if (i_addr == adc_conv_pkg::high_threshold_addr)
				high_threshold_reg <= i_wdata;
			if (i_addr == adc_conv_pkg::low_threshold_addr)
				low_threshold_reg <= i_wdata;
			if (i_addr == adc_conv_pkg::power_control_addr)
				amp_power_b_reg <= i_wdata[adc_conv_pkg::low_power_amp_bit];
		end
	end

	// ****************************************
	// Read path.
	// ****************************************
	// High byte read freezes the matching low bits.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			low_latch_reg     <= 5'h00;
			low_ovf_latch_reg <= 1'b0;
		end
		else if (i_rd && i_addr == adc_conv_pkg::result_high_byte_addr)
		begin
			low_latch_reg     <= result_reg[4:0]; // [RQ17]
			low_ovf_latch_reg <= overflow_reg;
		end
	end

	// Read data for one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rdata_reg <= 8'h00;
		else if (!i_rd)
			rdata_reg <= 8'h00;
		else
		begin
			unique case (i_addr)
				adc_conv_pkg::conversion_control_addr:
					rdata_reg <= {busy_reg, control_reg[6:0]}; // [RQ2]
				adc_conv_pkg::converter_config_status_addr:
					rdata_reg <= config_reg;
				adc_conv_pkg::result_high_byte_addr:
					rdata_reg <= result_reg[12:5]; // [RQ16]
				adc_conv_pkg::result_low_bits_addr:
					rdata_reg <= {low_latch_reg, 2'b00, low_ovf_latch_reg}; // [RQ22]
				adc_conv_pkg::high_threshold_addr:
					rdata_reg <= high_threshold_reg;
				adc_conv_pkg::low_threshold_addr:
					rdata_reg <= low_threshold_reg;
				adc_conv_pkg::power_control_addr:
					rdata_reg <= {7'h00, amp_power_b_reg};
				default:
					rdata_reg <= 8'h00;
			endcase
		end
	end

	assign o_rdata = rdata_reg;

	// ****************************************
	// Analog control outputs.
	// ****************************************
	// Registered drive of the analog controls and interrupt.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_vref_sel        <= adc_conv_pkg::vref_2v0;
			o_internal_ref_on <= 1'b1;
			o_vref_drive_out  <= 1'b0;
			o_pos_switch      <= 8'h00;
			o_neg_switch      <= 8'h00;
			o_ground_nodes    <= 1'b0;
			o_temp_sel        <= 1'b0;
			o_diff_short      <= 1'b0;
			o_input_buffered  <= 1'b0;
			o_amp_power_on    <= 1'b0;
			o_irq             <= 1'b0;
		end
		else
		begin
			o_vref_sel        <= {config_reg[7], control_reg[6]}; // [RQ6]
			o_internal_ref_on <= ({config_reg[7], control_reg[6]} == adc_conv_pkg::vref_1v0)
				|| ({config_reg[7], control_reg[6]} == adc_conv_pkg::vref_2v0); // [RQ6]
			o_vref_drive_out  <= control_reg[adc_conv_pkg::vref_drive_out_bit]; // [RQ7]
			o_pos_switch      <= pos_sw;
			o_neg_switch      <= neg_sw;
			o_ground_nodes    <= ground_sw;
			o_temp_sel        <= temp_sw;
			o_diff_short      <= short_sw;
			o_input_buffered  <= buffered;
			o_amp_power_on    <= !amp_power_b_reg; // [RQ20]
			o_irq <= (config_reg[6] && config_reg[4]) || (config_reg[5] && config_reg[3]); // [RQ24] [RQ15]
		end
	end

endmodule : adc_conversion_control

// file: test/adc_conversion_control_properties.sv
`timescale 1ns/10ps
// ********
// Port checker of the conversion control.
// ********
module adc_conversion_control_properties
(
	input wire logic        i_clk_sys,
	input wire logic        i_rst_b,
	input wire logic [11:0] i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	input wire logic        o_core_start,
	input wire logic        o_sample_strobe,
	input wire logic [1:0]  o_vref_sel,
	input wire logic        o_internal_ref_on,
	input wire logic [7:0]  o_pos_switch,
	input wire logic [7:0]  o_neg_switch,
	input wire logic        o_ground_nodes,
	input wire logic        o_temp_sel,
	input wire logic        o_diff_short
);
	logic        go_wr;
	logic [13:0] since_start_reg;
	logic [13:0] since_strobe_reg;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	// A write of one to the go bit.
	assign go_wr = i_wr && (i_addr == adc_conv_pkg::conversion_control_addr) && i_wdata[7];

	// Saturating counts since the last start and since the last result or start.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			since_start_reg <= 14'h0000;
		else if (o_core_start)
			since_start_reg <= 14'h0000;
		else if (since_start_reg != 14'h3fff)
			since_start_reg <= since_start_reg + 14'h0001;
	end

	// Restarts on every result so the update gap can be bounded.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			since_strobe_reg <= 14'h0000;
		else if (o_sample_strobe || o_core_start)
			since_strobe_reg <= 14'h0000;
		else if (since_strobe_reg != 14'h3fff)
			since_strobe_reg <= since_strobe_reg + 14'h0001;
	end

	AST_GO_STARTS: assert property (go_wr |=> o_core_start)
		else $error("no start pulse after go write");
	AST_START_CAUSE: assert property (o_core_start |-> $past(go_wr))
		else $error("start pulse without a go write of one");
	AST_FIRST_INTERVAL: assert property (o_sample_strobe |-> since_start_reg >= adc_conv_pkg::first_count)
		else $error("result came too soon after start");
	AST_UPDATE_GAP: assert property (o_sample_strobe |-> since_strobe_reg >= adc_conv_pkg::update_count)
		else $error("results closer than the update interval");
	AST_STROBE_PULSE: assert property (o_sample_strobe |=> (!o_sample_strobe)[*8])
		else $error("result strobe repeated too soon");
	AST_READ_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside the read answer cycle");
	AST_REF_DECODE: assert property (o_internal_ref_on == (o_vref_sel == 2'b01 || o_vref_sel == 2'b10))
		else $error("internal reference enable does not match select");
	AST_SWITCH_ONEHOT: assert property ($onehot0(o_pos_switch) && $onehot0(o_neg_switch))
		else $error("more than one input switch closed");
	AST_SPECIAL_EXCL: assert property (o_temp_sel |-> !o_diff_short && !o_ground_nodes)
		else $error("sensor select together with short or ground");
endmodule : adc_conversion_control_properties

bind adc_conversion_control adc_conversion_control_properties u_props
(
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_core_start(o_core_start),
	.o_sample_strobe(o_sample_strobe), .o_vref_sel(o_vref_sel),
	.o_internal_ref_on(o_internal_ref_on), .o_pos_switch(o_pos_switch),
	.o_neg_switch(o_neg_switch), .o_ground_nodes(o_ground_nodes),
	.o_temp_sel(o_temp_sel), .o_diff_short(o_diff_short)
);

// file: test/adc_conversion_control_test.sv
`timescale 1ns/10ps
// ********
// Self-checking bench of the conversion control.
// ********
module adc_conversion_control_test;
	localparam logic [11:0] a_ctl = adc_conv_pkg::conversion_control_addr;
	localparam logic [11:0] a_cfg = adc_conv_pkg::converter_config_status_addr;
	localparam logic [11:0] a_hi  = adc_conv_pkg::result_high_byte_addr;
	localparam logic [43:0] pos_t = 44'h02413560000;
	localparam logic [43:0] neg_t = 44'h13502452345;
	logic        i_clk_sys, i_rst_b, i_wr, i_rd, i_core_overflow, rd_d;
	logic [11:0] i_addr;
	logic [7:0]  i_wdata, o_rdata, o_pos_switch, o_neg_switch;
	logic [12:0] i_core_sample;
	logic        o_core_start, o_sample_strobe, o_internal_ref_on, o_vref_drive_out;
	logic        o_ground_nodes, o_temp_sel, o_diff_short, o_input_buffered;
	logic        o_amp_power_on, o_irq;
	logic [1:0]  o_vref_sel;
	logic [7:0]  exp_q[$];
	logic [31:0] seed;
	logic [13:0] smp;
	int          error_cnt, comparisons, cycles;

	adc_conversion_control u_dut
	(
		.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_sample(i_core_sample),
		.i_core_overflow(i_core_overflow), .o_core_start(o_core_start),
		.o_sample_strobe(o_sample_strobe), .o_vref_sel(o_vref_sel),
		.o_internal_ref_on(o_internal_ref_on), .o_vref_drive_out(o_vref_drive_out),
		.o_pos_switch(o_pos_switch), .o_neg_switch(o_neg_switch),
		.o_ground_nodes(o_ground_nodes), .o_temp_sel(o_temp_sel),
		.o_diff_short(o_diff_short), .o_input_buffered(o_input_buffered),
		.o_amp_power_on(o_amp_power_on), .o_irq(o_irq)
	);

	// Free-running 50 MHz clock.
	initial
	begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	// ********
	// Helpers.
	// ********
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift

	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr

	// Write, then let the registered outputs settle.
	task automatic wrw(input logic [11:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (2) @(posedge i_clk_sys);
	endtask : wrw

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
	endtask : rd

	// Counts edges from the write edge until a result strobe is seen.
	task automatic wait_res(input int e);
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk_sys);
			n++;
		end
		while (o_sample_strobe !== 1'b1 && n < 20000);
		chk("result_time", e, n);
	endtask : wait_res

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Takes the oldest note when a read answer appears.
	always @(posedge i_clk_sys)
	begin
		if (rd_d)
			chk("rdata", exp_q.pop_front(), o_rdata);
		rd_d <= i_rd;
	end

	// Cuts a hang short.
	always @(posedge i_clk_sys)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	// ********
	// Main sequence.
	// ********
	initial
	begin
		{i_rst_b, i_wr, i_rd, i_core_overflow, rd_d} = 5'h00;
		{i_addr, i_wdata, i_core_sample} = 33'h000000000;
		{error_cnt, comparisons, cycles} = 0;
		seed = 32'h0000004e;
		repeat (4) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		rd(a_ctl, 8'h00);
		rd(a_cfg, 8'h80);
		rd(12'h000, 8'h00);
		chk("amp_on", 1'b0, o_amp_power_on);
		chk("ref_sel", 2'b10, o_vref_sel);
		// Reference codes, output buffer only with an internal level.
		for (int i = 0; i < 3; i++)
		begin
			wr(a_cfg, {i[1], 7'h00});
			wrw(a_ctl, {1'b0, i[0], i[0], 5'h00});
			chk("ref_sel", i[1:0], o_vref_sel);
			chk("ref_on", i != 0, o_internal_ref_on);
			chk("ref_out", i == 1, o_vref_drive_out);
		end
		wrw(12'hf78, 8'h00);
		chk("amp_on", 1'b1, o_amp_power_on);
		wrw(12'hf78, 8'h01);
		chk("amp_on", 1'b0, o_amp_power_on);
		for (int m = 0; m < 8; m++)
		begin
			wrw(a_cfg, {5'h10, m[2:0]});
			chk("buffered", m == 1 || m == 5, o_input_buffered);
			chk("mode_sw", m[1] ? 8'h00 : 8'h01, o_pos_switch);
		end
		// Input decode in both buffer families.
		for (int d = 0; d < 2; d++)
		begin
			wr(a_cfg, {5'h10, d[0], 2'b00});
			for (int c = 0; c < 16; c++)
			begin
				wrw(a_ctl, {4'h0, c[3:0]});
				if (d == 0 && c < 8)
					chk("pos_se", 8'h01 << c, o_pos_switch);
				else if (d == 0 && c != 12 && c != 14 || d == 1 && c > 10 && c < 15)
					chk("open", 16'h0000, {o_pos_switch, o_neg_switch});
				else if (d == 1 && c < 11)
					chk("pair", {8'h01 << pos_t[43-4*c -: 4], 8'h01 << neg_t[43-4*c -: 4]},
						{o_pos_switch, o_neg_switch});
				chk("special", {d == 0 && c == 12, d == 0 && c == 14, d == 1 && c == 15},
					{o_ground_nodes, o_temp_sel, o_diff_short});
			end
		end
		// Single shot with a zero write and a restart in flight.
		wr(a_cfg, 8'h80);
		seed = xorshift(seed);
		smp = seed[13:0];
		i_core_sample <= smp[12:0];
		i_core_overflow <= smp[13];
		wr(a_ctl, 8'h80);
		wr(a_ctl, 8'h00);
		rd(a_ctl, 8'h80);
		repeat (3000) @(posedge i_clk_sys);
		wr(a_ctl, 8'h80);
		wait_res(5130);
		wr(a_hi, 8'h55);
		rd(a_hi, smp[12:5]);
		i_core_sample <= ~smp[12:0];
		rd(12'hf73, {smp[4:0], 2'b00, smp[13]});
		rd(a_ctl, 8'h00);
		// Alarms: set, write-zero, write-one clear, masked, differential.
		wr(12'hf74, 8'h10);
		wr(12'hf76, 8'hf0);
		wr(a_cfg, 8'hf0);
		i_core_sample <= {8'h20, smp[4:0]};
		wr(a_ctl, 8'h80);
		wait_res(5130);
		rd(a_cfg, 8'hd0);
		chk("irq", 1'b1, o_irq);
		wr(a_cfg, 8'h90);
		rd(a_cfg, 8'hd0);
		wr(a_cfg, 8'hc0);
		rd(a_cfg, 8'h80);
		i_core_sample <= {8'h80, 5'h00};
		wr(a_ctl, 8'h80);
		wait_res(5130);
		rd(a_cfg, 8'ha0);
		chk("irq", 1'b0, o_irq);
		wr(a_cfg, 8'ha4);
		wr(a_ctl, 8'h80);
		wait_res(5130);
		rd(a_cfg, 8'h84);
		// Continuous run, then reset in mid-run.
		wr(a_cfg, 8'h80);
		wr(a_ctl, 8'h90);
		wait_res(5130);
		seed = xorshift(seed);
		i_core_sample <= seed[12:0];
		wait_res(256);
		rd(a_hi, seed[12:5]);
		@(posedge i_clk_sys);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		rd(a_cfg, 8'h80);
		// Sensor input doubles both intervals.
		wr(a_cfg, 8'h81);
		wr(a_ctl, 8'h9e);
		wait_res(10259);
		wait_res(512);
		repeat (3) @(posedge i_clk_sys);
		end_of_test();
	end
endmodule : adc_conversion_control_test
